// ### sdpwm_defs.svh
// Constants for the split dual byte PWM timer: register offsets, field codes,
// reset values and bit positions.
// Assumes an eight-bit register port with byte addresses.
`ifndef SDPWM_DEFS_SVH
`define SDPWM_DEFS_SVH

// ****************************************************************************
// Register offsets
// ****************************************************************************
`define SDPWM_A_CLKSRC 8'h00
`define SDPWM_A_OUTEN 8'h01
`define SDPWM_A_OUTVAL 8'h02
`define SDPWM_A_MODE 8'h04
`define SDPWM_A_UNFLVL 8'h06
`define SDPWM_A_MATCHLVL 8'h07
`define SDPWM_A_COMMAND 8'h08
`define SDPWM_A_FLAGS 8'h0c
`define SDPWM_A_COUNT_LO 8'h20
`define SDPWM_A_COUNT_HI 8'h21
`define SDPWM_A_PERIOD_LO 8'h26
`define SDPWM_A_PERIOD_HI 8'h27
`define SDPWM_A_COMPARE_BASE 8'h28
`define SDPWM_A_COMPARE_LAST 8'h2f

// ****************************************************************************
// Field codes and positions
// ****************************************************************************
`define SDPWM_SRC_OFF 4'h0
`define SDPWM_SRC_EVENT_BIT 3
`define SDPWM_MODE_SPLIT 2'h2
`define SDPWM_CMD_LSB 2
`define SDPWM_CMD_RESTART 2'h2
`define SDPWM_CMD_RESET 2'h3
`define SDPWM_FLAG_UNF_LO 0
`define SDPWM_FLAG_UNF_HI 1
`define SDPWM_FLAG_MATCH_LSB 4

// ****************************************************************************
// Reset values
// ****************************************************************************
`define SDPWM_RST_PERIOD 8'hff
`define SDPWM_RST_BYTE 8'h00

`endif

// ### sdpwm_pkg.sv
// Types shared by the split dual byte PWM timer.
// Assumes sdpwm_defs.svh is compiled alongside.
`default_nettype none
package sdpwm_pkg;

    // Register port request from software.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sdpwm_bus_t;

    // Whole state of the timer.
    typedef struct packed {
        logic [3:0] clock_source_select;
        logic [7:0] channel_output_enable;
        logic [1:0] split_select_field;
        logic [7:0] unf_level;
        logic [7:0] match_level;
        logic [1:0][7:0] counter_value;
        logic [1:0][7:0] period;
        logic [7:0][7:0] compare_value_x;
        logic [7:0] waveform_output;
        logic [7:0] flags;
        logic [9:0] prescale;
        logic [7:0] ev_s1;
        logic [7:0] ev_s2;
        logic [7:0] ev_s3;
        logic [7:0] rdata;
        logic [5:0] events;
        logic [5:0] irq;
        logic [7:0] pin_out;
        logic [7:0] pin_oe_n;
    } sdpwm_state_t;

endpackage : sdpwm_pkg
`default_nettype wire

// ### sdpwm_timer.sv
// Split dual byte PWM timer: two eight-bit down-counters with eight
// compare channels overriding eight port pins.
// Assumes one clock, a one-cycle register port and port settings on ref_clk.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sdpwm_defs.svh"

module sdpwm_timer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Event channels from the routing network
    input wire logic [7:0] event_channel_in,
    // Port settings
    input wire logic [7:0] pin_output_value,
    input wire logic [7:0] pin_invert_enable,
    input wire logic [7:0] pin_is_output,
    // Port pins
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    // Events and interrupt requests
    output logic [5:0] event_out,
    output logic [5:0] irq_out
);

    // ************************************************************************
    // State
    // ************************************************************************
    localparam sdpwm_pkg::sdpwm_state_t RST_ST = '{
        clock_source_select: `SDPWM_SRC_OFF,
        channel_output_enable: `SDPWM_RST_BYTE,
        split_select_field: 2'h0,
        unf_level: `SDPWM_RST_BYTE,
        match_level: `SDPWM_RST_BYTE,
        counter_value: {2{`SDPWM_RST_BYTE}},
        period: {2{`SDPWM_RST_PERIOD}},
        compare_value_x: {8{`SDPWM_RST_BYTE}},
        waveform_output: `SDPWM_RST_BYTE,
        flags: `SDPWM_RST_BYTE,
        prescale: 10'h000,
        ev_s1: `SDPWM_RST_BYTE,
        ev_s2: `SDPWM_RST_BYTE,
        ev_s3: `SDPWM_RST_BYTE,
        rdata: `SDPWM_RST_BYTE,
        events: 6'h00,
        irq: 6'h00,
        pin_out: `SDPWM_RST_BYTE,
        pin_oe_n: 8'hff
    };

    sdpwm_pkg::sdpwm_state_t st_ff;
    sdpwm_pkg::sdpwm_state_t nxt_st;
    sdpwm_pkg::sdpwm_bus_t bus;
    logic split_on;
    logic pre_hit;
    logic tick;
    logic [1:0] cmd;
    logic [5:0] set_vec;
    logic [7:0] over;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign split_on = st_ff.split_select_field == `SDPWM_MODE_SPLIT;
    assign cmd = reg_wdata[`SDPWM_CMD_LSB +: 2];

    // ************************************************************************
    // Counter clock select
    // ************************************************************************
    always_comb begin
        case (st_ff.clock_source_select[2:0])
            3'h1: pre_hit = 1'b1;
            3'h2: pre_hit = st_ff.prescale[0];
            3'h3: pre_hit = &st_ff.prescale[1:0];
            3'h4: pre_hit = &st_ff.prescale[2:0];
            3'h5: pre_hit = &st_ff.prescale[5:0];
            3'h6: pre_hit = &st_ff.prescale[7:0];
            3'h7: pre_hit = &st_ff.prescale[9:0];
            default: pre_hit = 1'b0;
        endcase
        if (st_ff.clock_source_select[`SDPWM_SRC_EVENT_BIT]) begin
            tick = st_ff.ev_s2[st_ff.clock_source_select[2:0]] & ~st_ff.ev_s3[st_ff.clock_source_select[2:0]];
        end else begin
            tick = pre_hit;
        end
        tick = tick & split_on;
    end

    // ************************************************************************
    // Next state
    // ************************************************************************
    always_comb begin
        nxt_st = st_ff;
        set_vec = 6'h00;
        nxt_st.ev_s1 = event_channel_in;
        nxt_st.ev_s2 = st_ff.ev_s1;
        nxt_st.ev_s3 = st_ff.ev_s2;
        if (st_ff.clock_source_select == `SDPWM_SRC_OFF) begin
            nxt_st.prescale = 10'h000;
        end else begin
            nxt_st.prescale = st_ff.prescale + 10'h001;
        end
        // Both counters step on the same shared tick.
        if (tick) begin
            for (int k = 0; k < 2; k++) begin
                if (st_ff.counter_value[k] == 8'h00) begin
                    nxt_st.counter_value[k] = st_ff.period[k];
                    set_vec[k] = 1'b1;
                end else begin
                    nxt_st.counter_value[k] = st_ff.counter_value[k] - 8'h01;
                end
            end
            for (int c = 0; c < 8; c++) begin
                if (st_ff.counter_value[c / 4] == st_ff.compare_value_x[c]) begin
                    nxt_st.waveform_output[c] = 1'b1;
                    if (c < 4) begin
                        set_vec[2 + c] = 1'b1;
                    end
                end
                if (st_ff.counter_value[c / 4] == 8'h00) begin
                    nxt_st.waveform_output[c] = 1'b0;
                end
            end
        end
        nxt_st.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `SDPWM_A_CLKSRC: nxt_st.rdata = {4'h0, st_ff.clock_source_select};
                `SDPWM_A_OUTEN: nxt_st.rdata = st_ff.channel_output_enable;
                `SDPWM_A_OUTVAL: nxt_st.rdata = st_ff.waveform_output;
                `SDPWM_A_MODE: nxt_st.rdata = {6'h00, st_ff.split_select_field};
                `SDPWM_A_UNFLVL: nxt_st.rdata = st_ff.unf_level;
                `SDPWM_A_MATCHLVL: nxt_st.rdata = st_ff.match_level;
                `SDPWM_A_FLAGS: nxt_st.rdata = st_ff.flags;
                `SDPWM_A_COUNT_LO: nxt_st.rdata = st_ff.counter_value[0];
                `SDPWM_A_COUNT_HI: nxt_st.rdata = st_ff.counter_value[1];
                `SDPWM_A_PERIOD_LO: nxt_st.rdata = st_ff.period[0];
                `SDPWM_A_PERIOD_HI: nxt_st.rdata = st_ff.period[1];
                default: begin
                    if (bus.addr >= `SDPWM_A_COMPARE_BASE && bus.addr <= `SDPWM_A_COMPARE_LAST) begin
                        nxt_st.rdata = st_ff.compare_value_x[{bus.addr[0], bus.addr[2:1]}];
                    end
                end
            endcase
        end
        // Flags: a hardware set in the same cycle beats a software clear.
        nxt_st.flags = st_ff.flags;
        if (bus.wr && bus.addr == `SDPWM_A_FLAGS) begin
            nxt_st.flags = st_ff.flags & ~reg_wdata;
        end
        nxt_st.flags[`SDPWM_FLAG_UNF_LO] = nxt_st.flags[`SDPWM_FLAG_UNF_LO] | set_vec[0];
        nxt_st.flags[`SDPWM_FLAG_UNF_HI] = nxt_st.flags[`SDPWM_FLAG_UNF_HI] | set_vec[1];
        nxt_st.flags[`SDPWM_FLAG_MATCH_LSB +: 4] = nxt_st.flags[`SDPWM_FLAG_MATCH_LSB +: 4] | set_vec[5:2];
        // Register writes come last so that a counter write wins over the tick.
        if (bus.wr) begin
            case (bus.addr)
                `SDPWM_A_CLKSRC: nxt_st.clock_source_select = reg_wdata[3:0];
                `SDPWM_A_OUTEN: nxt_st.channel_output_enable = reg_wdata;
                `SDPWM_A_OUTVAL: begin
                    if (st_ff.clock_source_select == `SDPWM_SRC_OFF) begin
                        nxt_st.waveform_output = reg_wdata;
                    end
                end
                `SDPWM_A_MODE: nxt_st.split_select_field = reg_wdata[1:0];
                `SDPWM_A_UNFLVL: nxt_st.unf_level = {4'h0, reg_wdata[3:0]};
                `SDPWM_A_MATCHLVL: nxt_st.match_level = reg_wdata;
                `SDPWM_A_COUNT_LO: nxt_st.counter_value[0] = reg_wdata;
                `SDPWM_A_COUNT_HI: nxt_st.counter_value[1] = reg_wdata;
                `SDPWM_A_PERIOD_LO: nxt_st.period[0] = reg_wdata;
                `SDPWM_A_PERIOD_HI: nxt_st.period[1] = reg_wdata;
                `SDPWM_A_COMMAND: begin
                    if (cmd == `SDPWM_CMD_RESTART) begin
                        nxt_st.counter_value = '0;
                        nxt_st.waveform_output = 8'h00;
                    end
                end
                default: begin
                    if (bus.addr >= `SDPWM_A_COMPARE_BASE && bus.addr <= `SDPWM_A_COMPARE_LAST) begin
                        nxt_st.compare_value_x[{bus.addr[0], bus.addr[2:1]}] = reg_wdata;
                    end
                end
            endcase
        end
        if (bus.wr && bus.addr == `SDPWM_A_COMMAND && cmd == `SDPWM_CMD_RESET
            && st_ff.clock_source_select == `SDPWM_SRC_OFF) begin
            nxt_st = RST_ST;
            nxt_st.ev_s1 = event_channel_in;
            nxt_st.ev_s2 = st_ff.ev_s1;
            nxt_st.ev_s3 = st_ff.ev_s2;
        end
        nxt_st.events = set_vec;
        nxt_st.irq = {nxt_st.flags[`SDPWM_FLAG_MATCH_LSB +: 4] & {|st_ff.match_level[7:6],
            |st_ff.match_level[5:4], |st_ff.match_level[3:2], |st_ff.match_level[1:0]},
            nxt_st.flags[`SDPWM_FLAG_UNF_HI] & |st_ff.unf_level[3:2],
            nxt_st.flags[`SDPWM_FLAG_UNF_LO] & |st_ff.unf_level[1:0]};
        // Pins are worked out after a reset command so that they never glitch to zero.
        // Channels A-D sit on bit 0-3, E-H on bit 4-7 of the pin vector.
        over = st_ff.channel_output_enable & {8{split_on}};
        nxt_st.pin_out = ((over & st_ff.waveform_output) | (~over & pin_output_value)) ^ pin_invert_enable;
        nxt_st.pin_oe_n = ~pin_is_output;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign pin_out = st_ff.pin_out;
    assign pin_oe_n = st_ff.pin_oe_n;
    assign event_out = st_ff.events;
    assign irq_out = st_ff.irq;

    // ************************************************************************
    // Checks
    // ************************************************************************
    logic wr_count_lo;
    logic restart_wr;
    assign wr_count_lo = reg_wr && reg_addr == `SDPWM_A_COUNT_LO;
    assign restart_wr = reg_wr && reg_addr == `SDPWM_A_COMMAND && reg_wdata[3:2] == `SDPWM_CMD_RESTART;

    sequence s_restart_cmd;
        reg_wr && reg_addr == `SDPWM_A_COMMAND && reg_wdata[3:2] == `SDPWM_CMD_RESTART;
    endsequence
    sequence s_cleared;
        st_ff.counter_value == '0 && st_ff.waveform_output == 8'h00;
    endsequence
    sequence s_lo_match;
        tick && st_ff.counter_value[0] == st_ff.compare_value_x[0] && st_ff.counter_value[0] != 8'h00;
    endsequence
    sequence s_flag_and_event;
        st_ff.flags[`SDPWM_FLAG_MATCH_LSB] && event_out[2];
    endsequence

    property p_reload;
        @(posedge ref_clk) disable iff (!nrst)
        tick && st_ff.counter_value[0] == 8'h00 && !wr_count_lo && !restart_wr
        |=> st_ff.counter_value[0] == $past(st_ff.period[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("low counter did not reload period");

    property p_down;
        @(posedge ref_clk) disable iff (!nrst)
        tick && st_ff.counter_value[1] != 8'h00 && !(reg_wr && reg_addr == `SDPWM_A_COUNT_HI) && !restart_wr
        |=> st_ff.counter_value[1] == $past(st_ff.counter_value[1]) - 8'h01;
    endproperty
    a_down: assert property (p_down) else $error("high counter did not count down");

    property p_wr_prio;
        @(posedge ref_clk) disable iff (!nrst)
        wr_count_lo |=> st_ff.counter_value[0] == $past(reg_wdata);
    endproperty
    a_wr_prio: assert property (p_wr_prio) else $error("counter write lost");

    property p_stopped;
        @(posedge ref_clk) disable iff (!nrst)
        st_ff.clock_source_select == `SDPWM_SRC_OFF && !reg_wr |=> $stable(st_ff.counter_value);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved with no source");

    property p_unf;
        @(posedge ref_clk) disable iff (!nrst)
        tick && st_ff.counter_value[0] == 8'h00 |=> st_ff.flags[`SDPWM_FLAG_UNF_LO] && event_out[0];
    endproperty
    a_unf: assert property (p_unf) else $error("low underflow flag missing");

    property p_hi_unf;
        @(posedge ref_clk) disable iff (!nrst)
        tick && st_ff.counter_value[1] == 8'h00 |=> st_ff.flags[`SDPWM_FLAG_UNF_HI] && event_out[1];
    endproperty
    a_hi_unf: assert property (p_hi_unf) else $error("high underflow flag or event missing");

    property p_match;
        @(posedge ref_clk) disable iff (!nrst)
        s_lo_match |=> s_flag_and_event ##1 !event_out[2];
    endproperty
    a_match: assert property (p_match) else $error("match flag or event wrong");

    property p_bottom;
        @(posedge ref_clk) disable iff (!nrst)
        tick && st_ff.counter_value[1] == 8'h00 && !reg_wr |=> !st_ff.waveform_output[7];
    endproperty
    a_bottom: assert property (p_bottom) else $error("waveform not cleared at bottom");

    property p_pin;
        @(posedge ref_clk) disable iff (!nrst)
        split_on && st_ff.channel_output_enable[4]
        |=> pin_out[4] == ($past(st_ff.waveform_output[4]) ^ $past(pin_invert_enable[4]));
    endproperty
    a_pin: assert property (p_pin) else $error("pin 4 not overridden");

    property p_restart;
        @(posedge ref_clk) disable iff (!nrst)
        s_restart_cmd |=> s_cleared;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

    property p_reset_ignored;
        @(posedge ref_clk) disable iff (!nrst)
        reg_wr && reg_addr == `SDPWM_A_COMMAND && st_ff.clock_source_select != `SDPWM_SRC_OFF
        |=> st_ff.clock_source_select == $past(st_ff.clock_source_select);
    endproperty
    a_reset_ignored: assert property (p_reset_ignored) else $error("reset taken while running");

    property p_cmd_zero;
        @(posedge ref_clk) disable iff (!nrst)
        reg_rd && reg_addr == `SDPWM_A_COMMAND |=> reg_rdata == 8'h00;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("command reads nonzero");

endmodule // sdpwm_timer
`default_nettype wire

// ### sdpwm_pin_load.sv
// Model of the loads hanging on the eight port pins of the timer.
// Assumes pin_out and pin_oe_n come from the timer on ref_clk.
`timescale 1ns/100ps
`default_nettype none

module sdpwm_pin_load (
    // Clock
    input wire logic ref_clk,
    // Pins from the timer
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // Level seen on the wires
    output logic [7:0] pin_level
);
    logic [7:0] last_ff = 8'h00;

    // A released pin floats, so it shows a value that flips every cycle.
    always @(posedge ref_clk) begin
        last_ff <= pin_level;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = pin_oe_n[i] ? ~last_ff[i] : pin_out[i];
        end
    end
endmodule // sdpwm_pin_load

`default_nettype wire

// ### tb_split_dual_byte_pwm_timer.sv
// Self-checking testbench of the split dual byte PWM timer.
// Assumes sdpwm_defs.svh, sdpwm_timer and sdpwm_pin_load are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "sdpwm_defs.svh"

module tb_split_dual_byte_pwm_timer;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] event_channel_in = 8'h00;
    logic [7:0] pin_output_value = 8'h00;
    logic [7:0] pin_invert_enable = 8'h00;
    logic [7:0] pin_is_output = 8'h00;
    logic [7:0] reg_rdata, pin_out, pin_oe_n, pin_level;
    logic [5:0] event_out, irq_out;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int gap [6];
    int since [6];
    int npulse [6];
    int divs [8] = '{0, 1, 2, 4, 8, 64, 256, 1024};
    logic [7:0] rst_a [9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h0c, 8'h26, 8'h27};
    logic [7:0] rst_v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    logic [7:0] set_a [11] = '{8'h02, 8'h26, 8'h27, 8'h28, 8'h29, 8'h06, 8'h07, 8'h20, 8'h21, 8'h04, 8'h00};
    logic [7:0] set_d [11] = '{8'h00, 8'h03, 8'h05, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h02, 8'h01};

    // ****************************************
    // Design, load and clock
    // ****************************************
    sdpwm_timer uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_channel_in(event_channel_in),
        .pin_output_value(pin_output_value), .pin_invert_enable(pin_invert_enable),
        .pin_is_output(pin_is_output), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .event_out(event_out), .irq_out(irq_out));
    sdpwm_pin_load load (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Measures the spacing of each event pulse and cuts a hang short.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < 6; i++) begin
            if (event_out[i] === 1'b1) begin
                gap[i] <= since[i] + 1;
                since[i] <= 0;
                npulse[i] <= npulse[i] + 1;
            end else begin
                since[i] <= since[i] + 1;
            end
        end
        if (cycles == 60000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(16'(reg_rdata), 16'(exp), what);
    endtask

    task automatic pin_chk(input logic [7:0] exp, input string what);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(16'(pin_level), 16'(exp), what);
    endtask

    task automatic wait_pulses(input int i, input int n);
        int target;
        target = npulse[i] + n;
        while (npulse[i] < target) @(posedge ref_clk);
    endtask

    task automatic duty(input int b, input int n, input int exp, input string what);
        int c;
        c = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (pin_level[b] === 1'b1) c++;
        end
        chk(16'(c), 16'(exp), what);
    endtask

    task automatic ev_pulse(input int c);
        @(posedge ref_clk);
        event_channel_in <= 8'(1 << c);
        repeat (4) @(posedge ref_clk);
        event_channel_in <= 8'h00;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        pin_is_output <= 8'hff;
        for (int k = 0; k < 9; k++) rd(rst_a[k], rst_v[k], "reset value");
        wr(8'h10, 8'h5a);
        rd(8'h10, 8'h00, "unmapped");
        wr(`SDPWM_A_MODE, 8'h02);
        wr(`SDPWM_A_COUNT_LO, 8'h09);
        repeat (10) @(posedge ref_clk);
        rd(`SDPWM_A_COUNT_LO, 8'h09, "stopped count");
        wr(`SDPWM_A_OUTVAL, 8'ha5);
        rd(`SDPWM_A_OUTVAL, 8'ha5, "outputs while off");
        @(posedge ref_clk) pin_output_value <= 8'h30;
        wr(`SDPWM_A_OUTEN, 8'h0f);
        pin_chk(8'h35, "low override");
        @(posedge ref_clk) pin_invert_enable <= 8'h0f;
        wr(`SDPWM_A_OUTEN, 8'hff);
        pin_chk(8'haa, "inverted override");
        wr(`SDPWM_A_MODE, 8'h00);
        wr(`SDPWM_A_CLKSRC, 8'h01);
        repeat (10) @(posedge ref_clk);
        rd(`SDPWM_A_COUNT_LO, 8'h09, "normal mode count");
        pin_chk(8'h3f, "normal mode pins");
        wr(`SDPWM_A_CLKSRC, 8'h00);
        pin_invert_enable <= 8'h00;
        // Periods stay at three or more.
        for (int k = 0; k < 11; k++) wr(set_a[k], set_d[k]);
        wait_pulses(0, 2);
        chk(16'(gap[0]), 16'h0004, "low period");
        wait_pulses(1, 2);
        chk(16'(gap[1]), 16'h0006, "high period");
        wait_pulses(2, 2);
        chk(16'(gap[2]), 16'h0004, "match A event");
        duty(0, 40, 20, "channel A duty");
        duty(1, 40, 0, "channel B duty");
        duty(4, 60, 10, "channel E duty");
        @(posedge ref_clk) pin_invert_enable <= 8'h10;
        repeat (2) @(posedge ref_clk);
        duty(4, 60, 50, "channel E inverted");
        wr(`SDPWM_A_PERIOD_LO, 8'h07);
        wait_pulses(0, 3);
        wr(`SDPWM_A_PERIOD_LO, 8'h03);
        wait_pulses(0, 1);
        chk(16'(gap[0]), 16'h0008, "running period kept");
        wait_pulses(0, 1);
        chk(16'(gap[0]), 16'h0004, "new period");
        for (int k = 1; k < 8; k++) begin
            wr(`SDPWM_A_CLKSRC, 8'(k));
            wait_pulses(0, 3);
            chk(16'(gap[0]), 16'(4 * divs[k]), "prescaler rate");
        end
        wr(`SDPWM_A_CLKSRC, 8'h00);
        rd(`SDPWM_A_FLAGS, 8'hf3, "flags");
        chk(16'(irq_out), 16'h0005, "interrupt levels");
        wr(`SDPWM_A_FLAGS, 8'hff);
        rd(`SDPWM_A_FLAGS, 8'h00, "flags cleared");
        chk(16'(irq_out), 16'h0000, "interrupts cleared");
        for (int n = 0; n < 8; n++) begin
            wr(`SDPWM_A_COUNT_LO, 8'h0a);
            wr(`SDPWM_A_CLKSRC, 8'(8 + n));
            ev_pulse((n + 1) % 8);
            ev_pulse(n);
            rd(`SDPWM_A_COUNT_LO, 8'h09, "event channel count");
            wr(`SDPWM_A_CLKSRC, 8'h00);
        end
        wr(`SDPWM_A_OUTVAL, 8'hff);
        wr(`SDPWM_A_CLKSRC, 8'h0f);
        wr(`SDPWM_A_COUNT_HI, 8'h0b);
        wr(`SDPWM_A_COMMAND, 8'h08);
        rd(`SDPWM_A_COUNT_HI, 8'h00, "restart count");
        rd(`SDPWM_A_OUTVAL, 8'h00, "restart outputs");
        rd(`SDPWM_A_COMMAND, 8'h00, "command readback");
        wr(`SDPWM_A_COMMAND, 8'h0c);
        rd(`SDPWM_A_PERIOD_LO, 8'h03, "reset while running");
        wr(`SDPWM_A_CLKSRC, 8'h00);
        wr(`SDPWM_A_COMMAND, 8'h0c);
        for (int k = 0; k < 9; k++) rd(rst_a[k], rst_v[k], "after reset command");
        @(posedge ref_clk) pin_is_output <= 8'h0f;
        repeat (2) @(negedge ref_clk);
        chk(16'(pin_oe_n), 16'h00f0, "released pins");
        give_verdict();
    end
endmodule // tb_split_dual_byte_pwm_timer

`default_nettype wire
